// ---- logic/pabao_defines.vh ----
// Purpose: shared constants for the port A/B alternate function override logic
// Assumes: 8-bit ports, bit 0 is the lowest pin of each port
// Notes: definitions only, no logic
`ifndef PABAO_DEFINES_VH
`define PABAO_DEFINES_VH

// ****************************************************************
// port B pin positions of the alternate functions
// ****************************************************************
`define PABAO_T2A_BIT 7
`define PABAO_T1B_BIT 6
`define PABAO_T1A_BIT 5
`define PABAO_T0A_BIT 4
`define PABAO_MISO_BIT 3
`define PABAO_MOSI_BIT 2
`define PABAO_SCK_BIT 1
`define PABAO_SS_BIT 0

// ****************************************************************
// display duty codes: highest back-plane line in use
// ****************************************************************
`define PABAO_DUTY_STATIC 2'h0
`define PABAO_DUTY_HALF 2'h1
`define PABAO_DUTY_THIRD 2'h2
`define PABAO_DUTY_QUARTER 2'h3

// ****************************************************************
// reset values and fixed override levels
// ****************************************************************
`define PABAO_SYNC_RESET 8'h00
`define PABAO_ALL_OFF 8'h00
`define PABAO_ALL_ON 8'hff
`define PABAO_NIBBLE_OFF 4'h0

`endif

// ---- logic/pabao_override.v ----
// Purpose: alternate function override logic for general I/O ports A and B
// Assumes: one clock, synchronous active-high reset, pads resolved outside
// Notes: override signals are combinational; pad inputs pass two flops
//
// Overview of operation
// - port A: front-plane 3..0 high, back-plane low
// - front-plane pins: display on forces pad analog
// - back-plane 3..1 overridden per duty; 0 always
// - port B 7..4 carry four timer match outputs
// - match pins also carry PWM waveform
// - match enable replaces value; input gate by mask
// - port B pins feed pin-change sources 15..8
// - port B 3..0: MISO, MOSI, SCK, SS
// - controller forces MISO input; target uses direction
// - target forces MOSI input; controller uses direction
// - target forces SCK input; controller uses direction
// - target forces SS input; controller uses direction
// - target active only while select input low
// - forced input pull-up follows latch, global off
// - drive MISO, MOSI, SCK from matching SPI outputs
// - SS value untouched; inputs to SPI, pin-change
// - pull-up: override value, else dir/latch/off 010
// - driver enable: override value, else direction bit
// - pin value: override value, else latch bit
// - input enable: override value, else sleep state
`timescale 1ns/1ps
`include "pabao_defines.vh"

module pabao_override (
   input wire i_clock,
   input wire i_rst,
   // generic port control
   input wire [7:0] i_a_dir,
   input wire [7:0] i_a_latch,
   input wire [7:0] i_b_dir,
   input wire [7:0] i_b_latch,
   input wire i_global_pullup_off,
   input wire i_sleep_clamp,
   // display controller
   input wire i_display_driver_on,
   input wire [1:0] i_display_duty_select,
   // timers
   input wire i_t2_match_a_en,
   input wire i_t2_match_a_out,
   input wire i_t1_match_b_en,
   input wire i_t1_match_b_out,
   input wire i_t1_match_a_en,
   input wire i_t1_match_a_out,
   input wire i_t0_match_a_en,
   input wire i_t0_match_a_out,
   // pin-change interrupt logic
   input wire [7:0] i_pin_change_mask,
   input wire i_pin_change_group1_on,
   // serial interface core
   input wire i_serial_if_on,
   input wire i_controller_select,
   input wire i_spi_target_out,
   input wire i_spi_controller_out,
   input wire i_spi_clock_out,
   // pads
   input wire [7:0] i_pa_pad_in,
   input wire [7:0] i_pb_pad_in,
   output wire [7:0] o_pa_pad_out,
   output wire [7:0] o_pa_pad_oe_n,
   output wire [7:0] o_pa_pullup,
   output wire [7:0] o_pa_input_en,
   output wire [7:0] o_pa_lcd_link,
   output wire [7:0] o_pb_pad_out,
   output wire [7:0] o_pb_pad_oe_n,
   output wire [7:0] o_pb_pullup,
   output wire [7:0] o_pb_input_en,
   // synchronised pin reads
   output wire [7:0] o_pa_pin,
   output wire [7:0] o_pb_pin,
   output wire [7:0] o_pin_change_src,
   output wire o_spi_controller_in,
   output wire o_spi_target_in,
   output wire o_spi_clock_in,
   output wire o_spi_select_n,
   output wire o_spi_target_active
);

   // ****************************************************************
   // shared resolution functions
   // ****************************************************************

   // each override pair acts bit by bit: a set enable picks the override
   // value, a clear enable falls back to the plain port behaviour
   // pull-up: override, else on only for input with latch set and no global off
   function [7:0] resolve_pullup;
      input [7:0] oe;
      input [7:0] ov;
      input [7:0] dir;
      input [7:0] latch;
      input pull_off;
      begin
         resolve_pullup = (oe & ov) | (~oe & ~dir & latch & {8{~pull_off}});
      end
   endfunction

   // driver enable: override value, else direction bit
   function [7:0] resolve_drive;
      input [7:0] oe;
      input [7:0] ov;
      input [7:0] dir;
      begin
         resolve_drive = (oe & ov) | (~oe & dir);
      end
   endfunction

   // pin value: override value, else latch; only seen while driven
   function [7:0] resolve_value;
      input [7:0] oe;
      input [7:0] ov;
      input [7:0] latch;
      begin
         resolve_value = (oe & ov) | (~oe & latch);
      end
   endfunction

   // digital input enable: override, else off while the sleep clamp is on
   function [7:0] resolve_input;
      input [7:0] oe;
      input [7:0] ov;
      input sleep;
      begin
         resolve_input = (oe & ov) | (~oe & {8{~sleep}});
      end
   endfunction

   // back-plane line is in use when the duty reaches it
   function uses_back_plane;
      input [1:0] duty;
      input [1:0] line;
      begin
         uses_back_plane = (line <= duty);
      end
   endfunction

   // ****************************************************************
   // port A: display front-plane and back-plane lines
   // ****************************************************************

   wire [7:0] a_lcd;
   wire [7:0] a_drive;
   wire [7:0] a_value;

   // back-plane lines beyond the duty stay ordinary port pins, so spare
   // lines remain usable as general I/O while the display runs
   // upper nibble is front-plane 3..0, lower nibble back-plane 3..0
   assign a_lcd[7:4] = {4{i_display_driver_on}};
   assign a_lcd[3] = i_display_driver_on &
                     uses_back_plane(i_display_duty_select, 2'h3);
   assign a_lcd[2] = i_display_driver_on &
                     uses_back_plane(i_display_duty_select, 2'h2);
   assign a_lcd[1] = i_display_driver_on &
                     uses_back_plane(i_display_duty_select, 2'h1);
   assign a_lcd[0] = i_display_driver_on;

   // an overridden pin loses pull-up, driver and input; values are all zero
   assign o_pa_pullup = resolve_pullup(a_lcd, `PABAO_ALL_OFF, i_a_dir,
                                       i_a_latch, i_global_pullup_off);
   assign a_drive = resolve_drive(a_lcd, `PABAO_ALL_OFF, i_a_dir);
   assign a_value = resolve_value(`PABAO_ALL_OFF, `PABAO_ALL_OFF, i_a_latch);
   assign o_pa_input_en = resolve_input(a_lcd, `PABAO_ALL_OFF, i_sleep_clamp);
   assign o_pa_lcd_link = a_lcd;

   // undriven pads show zero so the pad model sees a stable level
   assign o_pa_pad_out = a_value & a_drive;
   assign o_pa_pad_oe_n = ~a_drive;

   // ****************************************************************
   // port B: timer match outputs, serial interface, pin change
   // ****************************************************************

   wire spi_ctl;
   wire spi_tgt;
   wire [7:0] b_force_in;
   wire [7:0] b_pull_override_val;
   wire [7:0] b_value_override_en;
   wire [7:0] b_value_override_val;
   wire [7:0] b_input_gate_override_en;
   wire [7:0] b_drive;
   wire [7:0] b_value;

   // the role decides which side owns each serial pin; a disabled interface
   // hands all four pins back to plain port control
   assign spi_ctl = i_serial_if_on & i_controller_select;
   assign spi_tgt = i_serial_if_on & ~i_controller_select;

   // MISO is an input as controller, the other three as target
   assign b_force_in[`PABAO_MISO_BIT] = spi_ctl;
   assign b_force_in[`PABAO_MOSI_BIT] = spi_tgt;
   assign b_force_in[`PABAO_SCK_BIT] = spi_tgt;
   assign b_force_in[`PABAO_SS_BIT] = spi_tgt;
   // timer pins never touch pull-up or direction
   assign b_force_in[7:4] = `PABAO_NIBBLE_OFF;

   // a forced input keeps its latch-driven pull-up unless globally off
   assign b_pull_override_val[7:4] = `PABAO_NIBBLE_OFF;
   assign b_pull_override_val[3:0] = i_b_latch[3:0] & {4{~i_global_pullup_off}};

   // the timer drives its waveform, compare or PWM alike, once enabled
   assign b_value_override_en[`PABAO_T2A_BIT] = i_t2_match_a_en;
   assign b_value_override_val[`PABAO_T2A_BIT] = i_t2_match_a_out;
   assign b_value_override_en[`PABAO_T1B_BIT] = i_t1_match_b_en;
   assign b_value_override_val[`PABAO_T1B_BIT] = i_t1_match_b_out;
   assign b_value_override_en[`PABAO_T1A_BIT] = i_t1_match_a_en;
   assign b_value_override_val[`PABAO_T1A_BIT] = i_t1_match_a_out;
   assign b_value_override_en[`PABAO_T0A_BIT] = i_t0_match_a_en;
   assign b_value_override_val[`PABAO_T0A_BIT] = i_t0_match_a_out;

   // serial outputs; the select pin value is never replaced
   assign b_value_override_en[`PABAO_MISO_BIT] = spi_tgt;
   assign b_value_override_val[`PABAO_MISO_BIT] = i_spi_target_out;
   assign b_value_override_en[`PABAO_MOSI_BIT] = spi_ctl;
   assign b_value_override_val[`PABAO_MOSI_BIT] = i_spi_controller_out;
   assign b_value_override_en[`PABAO_SCK_BIT] = spi_ctl;
   assign b_value_override_val[`PABAO_SCK_BIT] = i_spi_clock_out;
   assign b_value_override_en[`PABAO_SS_BIT] = 1'b0;
   assign b_value_override_val[`PABAO_SS_BIT] = 1'b0;

   // a watched pin keeps its input alive even in deep sleep
   assign b_input_gate_override_en = i_pin_change_mask & {8{i_pin_change_group1_on}};

   // a match output only reaches the pad once software set direction
   assign o_pb_pullup = resolve_pullup(b_force_in, b_pull_override_val, i_b_dir,
                                       i_b_latch, i_global_pullup_off);
   assign b_drive = resolve_drive(b_force_in, `PABAO_ALL_OFF, i_b_dir);
   assign b_value = resolve_value(b_value_override_en, b_value_override_val,
                                  i_b_latch);
   assign o_pb_input_en = resolve_input(b_input_gate_override_en, `PABAO_ALL_ON,
                                        i_sleep_clamp);

   assign o_pb_pad_out = b_value & b_drive;
   assign o_pb_pad_oe_n = ~b_drive;

   // ****************************************************************
   // pad input synchronisers
   // ****************************************************************

   reg [7:0] pa_sync1;
   reg [7:0] pa_sync2;
   reg [7:0] pb_sync1;
   reg [7:0] pb_sync2;
   wire [7:0] pa_gated;
   wire [7:0] pb_gated;
   reg [7:0] pa_en_d1;
   reg [7:0] pa_en_d2;
   reg [7:0] pb_en_d1;
   reg [7:0] pb_en_d2;

   // raw pad levels pass both stages before any gate reads them; the input
   // enable is delayed alongside, so the clamp lines up with the level it masks
   // a read lags the pad by two edges; a pulse shorter than a clock can be lost
   always @(posedge i_clock) begin
      if (i_rst) begin
         pa_sync1 <= `PABAO_SYNC_RESET;
         pa_sync2 <= `PABAO_SYNC_RESET;
         pb_sync1 <= `PABAO_SYNC_RESET;
         pb_sync2 <= `PABAO_SYNC_RESET;
         pa_en_d1 <= `PABAO_SYNC_RESET;
         pa_en_d2 <= `PABAO_SYNC_RESET;
         pb_en_d1 <= `PABAO_SYNC_RESET;
         pb_en_d2 <= `PABAO_SYNC_RESET;
      end else begin
         pa_sync1 <= i_pa_pad_in;
         pa_sync2 <= pa_sync1;
         pb_sync1 <= i_pb_pad_in;
         pb_sync2 <= pb_sync1;
         pa_en_d1 <= o_pa_input_en;
         pa_en_d2 <= pa_en_d1;
         pb_en_d1 <= o_pb_input_en;
         pb_en_d2 <= pb_en_d1;
      end
   end

   // a disabled input reads low, as the sleep clamp would make it
   assign pa_gated = pa_sync2 & pa_en_d2;
   assign pb_gated = pb_sync2 & pb_en_d2;

   // ****************************************************************
   // routing of pin inputs to the peripherals
   // ****************************************************************

   assign o_pa_pin = pa_gated;
   assign o_pb_pin = pb_gated;

   // every port B pin feeds the pin-change logic, bit 7 as source 15
   assign o_pin_change_src = pb_gated;

   // MISO to the controller input, MOSI to the target input
   assign o_spi_controller_in = pb_gated[`PABAO_MISO_BIT];
   assign o_spi_target_in = pb_gated[`PABAO_MOSI_BIT];
   assign o_spi_clock_in = pb_gated[`PABAO_SCK_BIT];
   assign o_spi_select_n = pb_gated[`PABAO_SS_BIT];

   // target mode only wakes while the far controller holds select low
   assign o_spi_target_active = spi_tgt & ~pb_gated[`PABAO_SS_BIT];

endmodule // pabao_override

// ---- bench/pabao_props_properties.sv ----
// Purpose: port-level checks on the A/B override block
// Assumes: one clock, sync active-high reset
// Notes: bound to the top module, watches a subset of its ports
`timescale 1ns/1ps
module pabao_props (
   input wire i_clock,
   input wire i_rst,
   input wire i_display_driver_on,
   input wire [1:0] i_display_duty_select,
   input wire [7:0] i_b_dir,
   input wire i_serial_if_on,
   input wire i_controller_select,
   input wire [7:0] i_pb_pad_in,
   input wire [7:0] o_pa_pad_oe_n,
   input wire [7:0] o_pa_lcd_link,
   input wire [7:0] o_pb_pad_oe_n,
   input wire [7:0] o_pb_input_en,
   input wire [7:0] o_pb_pin,
   input wire [7:0] o_pin_change_src,
   input wire o_spi_select_n,
   input wire o_spi_target_active
);
   // ********
   // checks
   // ********
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // synchroniser output is only meaningful after two clean edges
   sequence s_quiet;
      !i_rst [*3];
   endsequence
   sequence s_ctrl_on;
      i_serial_if_on && i_controller_select;
   endsequence
   a_front_plane_off: assert property (i_display_driver_on |->
      o_pa_pad_oe_n[7:4] == 4'hf && o_pa_lcd_link[7:4] == 4'hf) else $error("front plane held");
   a_back_plane_duty: assert property (i_display_driver_on |-> o_pa_lcd_link[3:0] ==
      {i_display_duty_select == 2'h3, i_display_duty_select >= 2'h2,
      i_display_duty_select != 2'h0, 1'b1}) else $error("back plane duty wrong");
   a_lcd_idle: assert property (!i_display_driver_on |-> o_pa_lcd_link == 8'h00)
      else $error("pad linked while display off");
   a_timer_dir: assert property (o_pb_pad_oe_n[7:4] == ~i_b_dir[7:4])
      else $error("timer pin direction overridden");
   a_miso_forced: assert property (s_ctrl_on |-> o_pb_pad_oe_n[3])
      else $error("miso driven as controller");
   a_target_forced: assert property (i_serial_if_on && !i_controller_select |->
      o_pb_pad_oe_n[2:0] == 3'h7) else $error("target input driven");
   a_pin_sync: assert property (s_quiet |->
      o_pb_pin == $past(i_pb_pad_in & o_pb_input_en, 2))
      else $error("pin read not two edges late");
   a_change_feed: assert property (o_pin_change_src == o_pb_pin)
      else $error("pin change source differs");
   a_target_sel: assert property (o_spi_target_active ==
      (i_serial_if_on && !i_controller_select && !o_spi_select_n))
      else $error("target active wrong");
endmodule // pabao_props
bind pabao_override pabao_props i_props (.i_clock, .i_rst, .i_display_driver_on,
   .i_display_duty_select, .i_b_dir, .i_serial_if_on, .i_controller_select, .i_pb_pad_in,
   .o_pa_pad_oe_n, .o_pa_lcd_link, .o_pb_pad_oe_n, .o_pb_input_en, .o_pb_pin,
   .o_pin_change_src, .o_spi_select_n, .o_spi_target_active);

// ---- bench/pabao_far_side.sv ----
// Purpose: far side of the pads: display glass, serial peer, loads
// Assumes: peer drives only pads the block has released
// Notes: a floating pad without pull-up toggles every cycle
`timescale 1ns/1ps
module pabao_far_side (
   input wire i_clock,
   input wire [7:0] i_oe_n,
   input wire [7:0] i_out,
   input wire [7:0] i_pullup,
   input wire [7:0] i_ext,
   input wire [7:0] i_ext_en,
   output wire [7:0] o_pad
);
   // ********
   // pad resolution
   // ********
   logic toggle = 1'b0;
   // a moving float level keeps a stale read from passing
   always @(posedge i_clock) begin
      toggle <= ~toggle;
   end
   // peer select level comes from i_ext, low selects the target
   assign o_pad = (~i_oe_n & i_out) | (i_oe_n & i_ext_en & i_ext) |
      (i_oe_n & ~i_ext_en & (i_pullup | {8{toggle}}));
endmodule // pabao_far_side

// ---- bench/tb_top.sv ----
// Purpose: self-checking bench for the A/B override block
// Assumes: 40 MHz clock, sync reset held 10 cycles
// Notes: seeded random stimulus plus a duty and serial mode sweep
`timescale 1ns/1ps
module tb_top;
   // ********
   // stimulus and wires
   // ********
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic i_global_pullup_off, i_sleep_clamp, i_display_driver_on, i_pin_change_group1_on;
   logic i_t2_match_a_en, i_t2_match_a_out, i_t1_match_b_en, i_t1_match_b_out;
   logic i_t1_match_a_en, i_t1_match_a_out, i_t0_match_a_en, i_t0_match_a_out;
   logic i_serial_if_on, i_controller_select, i_spi_target_out, i_spi_controller_out;
   logic i_spi_clock_out;
   logic [1:0] i_display_duty_select;
   logic [7:0] i_a_dir, i_a_latch, i_b_dir, i_b_latch, i_pin_change_mask;
   logic [31:0] ext;
   logic [7:0] s1a, s2a, s1b, s2b, ea, eb;
   wire [7:0] i_pa_pad_in, i_pb_pad_in, o_pa_pad_out, o_pa_pad_oe_n, o_pa_pullup;
   wire [7:0] o_pa_input_en, o_pa_lcd_link, o_pb_pad_out, o_pb_pad_oe_n, o_pb_pullup;
   wire [7:0] o_pb_input_en, o_pa_pin, o_pb_pin, o_pin_change_src;
   wire o_spi_controller_in, o_spi_target_in, o_spi_clock_in, o_spi_select_n;
   wire o_spi_target_active;
   integer seed = 72, error_cnt = 0, check_count = 0, cycles = 0;
   always #12.5 i_clock = ~i_clock;
   pabao_override i_dut (.i_clock, .i_rst, .i_a_dir, .i_a_latch, .i_b_dir, .i_b_latch,
      .i_global_pullup_off, .i_sleep_clamp, .i_display_driver_on, .i_display_duty_select,
      .i_t2_match_a_en, .i_t2_match_a_out, .i_t1_match_b_en, .i_t1_match_b_out,
      .i_t1_match_a_en, .i_t1_match_a_out, .i_t0_match_a_en, .i_t0_match_a_out,
      .i_pin_change_mask, .i_pin_change_group1_on, .i_serial_if_on, .i_controller_select,
      .i_spi_target_out, .i_spi_controller_out, .i_spi_clock_out, .i_pa_pad_in, .i_pb_pad_in,
      .o_pa_pad_out, .o_pa_pad_oe_n, .o_pa_pullup, .o_pa_input_en, .o_pa_lcd_link,
      .o_pb_pad_out, .o_pb_pad_oe_n, .o_pb_pullup, .o_pb_input_en, .o_pa_pin, .o_pb_pin,
      .o_pin_change_src, .o_spi_controller_in, .o_spi_target_in, .o_spi_clock_in,
      .o_spi_select_n, .o_spi_target_active);
   pabao_far_side i_far_a (.i_clock, .i_oe_n(o_pa_pad_oe_n), .i_out(o_pa_pad_out),
      .i_pullup(o_pa_pullup), .i_ext(ext[7:0]), .i_ext_en(ext[15:8]), .o_pad(i_pa_pad_in));
   pabao_far_side i_far_b (.i_clock, .i_oe_n(o_pb_pad_oe_n), .i_out(o_pb_pad_out),
      .i_pullup(o_pb_pullup), .i_ext(ext[23:16]), .i_ext_en(ext[31:24]), .o_pad(i_pb_pad_in));
   // ********
   // helpers
   // ********
   function automatic [7:0] mix(input [7:0] oe, input [7:0] ov, input [7:0] dflt);
      mix = (oe & ov) | (~oe & dflt);
   endfunction
   task automatic chk(input string what, input [7:0] exp, input [7:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_sim();
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // one write per input per edge; the sweep pins display, duty and serial mode
   task automatic shake(input bit sweep, input [2:0] k);
      logic [31:0] r;
      logic [31:0] q;
      r = $random(seed);
      q = $random(seed);
      if (sweep) begin
         r[31:27] = {1'b1, k[1:0], 1'b1, k[2]};
         q[31:28] = 4'hf;
      end
      {i_display_driver_on, i_display_duty_select, i_serial_if_on, i_controller_select,
         i_pin_change_mask, i_global_pullup_off, i_sleep_clamp, i_pin_change_group1_on,
         i_t2_match_a_en, i_t2_match_a_out, i_t1_match_b_en, i_t1_match_b_out,
         i_t1_match_a_en, i_t1_match_a_out, i_t0_match_a_en, i_t0_match_a_out,
         i_spi_target_out, i_spi_controller_out, i_spi_clock_out} <= r[31:5];
      {i_b_dir, i_a_dir, i_a_latch, i_b_latch} <= q;
      ext <= $random(seed);
   endtask
   // ********
   // checking
   // ********
   // judged mid-cycle, once every combinational path has settled
   // nothing is judged before the first edge, while the flops are still unknown
   always @(negedge i_clock) if (cycles != 0) begin : judge
      logic [7:0] lm, fo, vo, vv, dra, drb, pull_ok;
      logic spi_c, spi_t;
      spi_c = i_serial_if_on & i_controller_select;
      spi_t = i_serial_if_on & ~i_controller_select;
      pull_ok = {8{~i_global_pullup_off}};
      lm = {{4{i_display_driver_on}}, i_display_driver_on & (i_display_duty_select == 2'h3),
         i_display_driver_on & (i_display_duty_select >= 2'h2),
         i_display_driver_on & (i_display_duty_select != 2'h0), i_display_driver_on};
      fo = {4'h0, spi_c, {3{spi_t}}};
      vo = {i_t2_match_a_en, i_t1_match_b_en, i_t1_match_a_en, i_t0_match_a_en,
         spi_t, spi_c, spi_c, 1'b0};
      vv = {i_t2_match_a_out, i_t1_match_b_out, i_t1_match_a_out, i_t0_match_a_out,
         i_spi_target_out, i_spi_controller_out, i_spi_clock_out, 1'b0};
      dra = mix(lm, 8'h00, i_a_dir);
      drb = mix(fo, 8'h00, i_b_dir);
      ea = mix(lm, 8'h00, {8{~i_sleep_clamp}});
      eb = mix(i_pin_change_mask & {8{i_pin_change_group1_on}}, 8'hff, {8{~i_sleep_clamp}});
      chk("pa_oe_n", ~dra, o_pa_pad_oe_n);
      chk("pa_pullup", mix(lm, 8'h00, ~i_a_dir & i_a_latch & pull_ok), o_pa_pullup);
      chk("pa_out", dra & i_a_latch, o_pa_pad_out);
      chk("pa_in_en", ea, o_pa_input_en);
      chk("pa_link", lm, o_pa_lcd_link);
      chk("pb_oe_n", ~drb, o_pb_pad_oe_n);
      chk("pb_pullup", mix(fo, i_b_latch & pull_ok, ~i_b_dir & i_b_latch & pull_ok),
         o_pb_pullup);
      chk("pb_out", drb & mix(vo, vv, i_b_latch), o_pb_pad_out);
      chk("pb_in_en", eb, o_pb_input_en);
      chk("pa_pin", s2a, o_pa_pin);
      chk("pb_pin", s2b, o_pb_pin);
      chk("pc_src", s2b, o_pin_change_src);
      chk("spi_in", {4'h0, s2b[3:0]}, {4'h0, o_spi_controller_in, o_spi_target_in,
         o_spi_clock_in, o_spi_select_n});
      chk("tgt_act", {7'h00, spi_t & ~s2b[0]}, {7'h00, o_spi_target_active});
      ea = ea & i_pa_pad_in;
      eb = eb & i_pb_pad_in;
   end
   // bench copy of the two-flop synchroniser, plus the hang limit
   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      {s2a, s1a, s2b, s1b} <= i_rst ? 32'h0000_0000 : {s1a, ea, s1b, eb};
      if (cycles == 6000) begin
         error_cnt++;
         end_sim();
      end
   end
   task automatic run(input integer n);
      repeat (n) begin
         @(posedge i_clock);
         shake(1'b0, 3'h0);
      end
   endtask
   // main sequence: reset, mode sweep, random traffic, reset in mid-run
   initial begin
      shake(1'b0, 3'h0);
      repeat (10) @(posedge i_clock);
      i_rst <= 1'b0;
      for (int k = 0; k < 8; k++) begin
         @(posedge i_clock);
         shake(1'b1, k[2:0]);
      end
      run(3000);
      i_rst <= 1'b1;
      repeat (3) @(posedge i_clock);
      i_rst <= 1'b0;
      run(500);
      end_sim();
   end
endmodule // tb_top
